// File: include/bsc_cfg.svh
`ifndef BSC_CFG_SVH
`define BSC_CFG_SVH

// Control word layout
`define BSC_WORD_W 16
`define BSC_OP_MSB 15
`define BSC_OP_LSB 13
`define BSC_OP_SOFTWARE 3'h4
`define BSC_OP_BOOST 3'h3
`define BSC_ECHO_BIT 12
`define BSC_CODE_MSB 11
`define BSC_CODE_LSB 0
`define BSC_CODE_RESET 12'h555
`define BSC_CODE_SERVICE 12'h195

// Boost control fields
`define BSC_COMP_BIT 6
`define BSC_PHASE_MSB 5
`define BSC_PHASE_LSB 4
`define BSC_RATE_MSB 3
`define BSC_RATE_LSB 2
`define BSC_VLIM_MSB 1
`define BSC_VLIM_LSB 0
`define BSC_BOOST_USED_W 7

// Reset values and undefined rate code
`define BSC_COMP_RST 1'h0
`define BSC_PHASE_RST 2'h0
`define BSC_RATE_RST 2'h1
`define BSC_VLIM_RST 2'h0
`define BSC_TOGGLE_RST 1'h0
`define BSC_RATE_UNDEF 2'h3

// Readback address codes and status layout
`define BSC_RD_ADDR_W 5
`define BSC_RD_STATUS 5'h18
`define BSC_RD_BOOST 5'h1a
`define BSC_STAT_TOGGLE_BIT 11

// Timing
`define BSC_CLK_HZ 10000000
`define BSC_RATE0_HZ 250000
`define BSC_RATE1_HZ 410000
`define BSC_RATE2_HZ 650000
`define BSC_WDT_TIMEOUT_US 10000
`define BSC_DIV_W 8

`endif

// File: include/bsc_pkg.sv
package bsc_pkg;

    typedef enum logic [1:0] {
        BSC_PH_ALL_SAME,
        BSC_PH_AB_CD,
        BSC_PH_AC_BD,
        BSC_PH_QUAD
    } bsc_phasing_e;

    typedef enum logic [1:0] {
        BSC_WD_IDLE,
        BSC_WD_RUN,
        BSC_WD_FAULT
    } bsc_wd_state_e;

endpackage

// File: verilog/bsc_watchdog.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_watchdog #(
    parameter int unsigned TIMEOUT_CYCLES = 100000
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic service_i,
    input wire logic clear_i,
    output logic alert_o
);

    localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

    bsc_pkg::bsc_wd_state_e state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic alert_q, alert_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            bsc_pkg::BSC_WD_IDLE: begin
                cnt_d = '0;
                if (enable_i) begin
                    state_d = bsc_pkg::BSC_WD_RUN;
                end
            end
            bsc_pkg::BSC_WD_RUN: begin
                // Service in the expiry cycle still counts as in time
                if (service_i) begin
                    cnt_d = '0;
                end else if (cnt_q == LAST) begin
                    state_d = bsc_pkg::BSC_WD_FAULT;
                end else begin
                    cnt_d = cnt_q + CW'(1);
                end
            end
            bsc_pkg::BSC_WD_FAULT: begin
                cnt_d = '0;
                if (service_i) begin
                    state_d = bsc_pkg::BSC_WD_RUN;
                end
            end
        endcase
        if (!enable_i || clear_i) begin
            state_d = bsc_pkg::BSC_WD_IDLE;
            cnt_d = '0;
        end
        alert_d = (state_d == bsc_pkg::BSC_WD_FAULT);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= bsc_pkg::BSC_WD_IDLE;
            cnt_q <= '0;
            alert_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            alert_q <= alert_d;
        end
    end

    assign alert_o = alert_q;

endmodule // bsc_watchdog

`default_nettype wire

// File: verilog/bsc_phase_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"

module bsc_phase_gen #(
    parameter int unsigned CHANNELS = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] rate_i,
    input wire logic [1:0] phasing_i,
    output logic [CHANNELS-1:0] switch_clk_o
);

    localparam int unsigned DW = `BSC_DIV_W;

    // Code 11 is never stored; the default branch gives code 10 its divisor and covers code 11 defensively
    function automatic logic [DW-1:0] divisor(input logic [1:0] rate);
        case (rate)
            2'h0: divisor = DW'(`BSC_CLK_HZ / `BSC_RATE0_HZ);
            2'h1: divisor = DW'(`BSC_CLK_HZ / `BSC_RATE1_HZ);
            default: divisor = DW'(`BSC_CLK_HZ / `BSC_RATE2_HZ);
        endcase
    endfunction

    function automatic logic [DW-1:0] offset(input logic [1:0] ph, input int ch,
                                             input logic [DW-1:0] div);
        case (bsc_pkg::bsc_phasing_e'(ph))
            bsc_pkg::BSC_PH_AB_CD: offset = (ch >= 2) ? (div >> 1) : '0;
            bsc_pkg::BSC_PH_AC_BD: offset = (ch % 2 == 1) ? (div >> 1) : '0;
            bsc_pkg::BSC_PH_QUAD: offset = DW'((ch * int'(div)) / 4);
            default: offset = '0;
        endcase
    endfunction

    logic [DW-1:0] div;
    logic [DW-1:0] cnt_q, cnt_d;
    logic [CHANNELS-1:0] clk_q, clk_d;

    assign div = divisor(rate_i);

    always_comb begin
        // A rate change can leave the count past the new end; wrap at once
        if (cnt_q >= div - DW'(1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + DW'(1);
        end
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        logic [DW:0] sum;
        logic [DW-1:0] ph;
        assign sum = {1'b0, cnt_q} + {1'b0, offset(phasing_i, g, div)};
        assign ph = (sum >= {1'b0, div}) ? DW'(sum - {1'b0, div}) : sum[DW-1:0];
        assign clk_d[g] = (ph < (div >> 1));
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            clk_q <= '0;
        end else begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign switch_clk_o = clk_q;

endmodule // bsc_phase_gen

`default_nettype wire

// File: verilog/bsc_regs.sv
// Overview of operation
// - Word with top bits 100 is a software write: echo bit D12, code D11..D0.
// - Each software write except code 0x555 copies the echo bit into status bit D11.
// - Software code 0x555 resets the boost fields and echo bit, clears the watchdog and pulses soft_reset_o.
// - Code 0x195 services the watchdog and restarts its timeout count.
// - Enabled watchdog without service in time raises the alert output.
// - Word with top bits 011 writes boost control; D12..D7 ignored.
// - D6 compensation: 0 internal resistor (default), 1 external resistor.
// - D5..D4 sets phasing of the four channel switching clocks.
// - D3..D2 sets switching rate divided from oscillator; 01 default.
// - D1..D0 sets maximum boost voltage code; 00 default.
// - Boost control register reads back at address code 11010.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_cfg.svh"

module bsc_regs #(
    parameter int unsigned WDT_TIMEOUT_CYCLES =
        (`BSC_WDT_TIMEOUT_US / 1000) * (`BSC_CLK_HZ / 1000),
    parameter int unsigned CHANNELS = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_valid_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_req_i,
    input wire logic [4:0] rd_addr_i,
    input wire logic wdt_enable_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    output logic soft_reset_o,
    output logic alert_o,
    output logic user_toggle_o,
    output logic boost_compensation_select_o,
    output logic [1:0] boost_phasing_select_o,
    output logic [1:0] boost_switching_rate_select_o,
    output logic [1:0] boost_voltage_limit_select_o,
    output logic [CHANNELS-1:0] boost_switch_clk_o
);

    logic [2:0] opcode;
    logic [11:0] code;
    logic sw_wr, boost_wr, reset_cmd, service_cmd;

    logic comp_q, comp_d;
    logic [1:0] phase_q, phase_d;
    logic [1:0] rate_q, rate_d;
    logic [1:0] vlim_q, vlim_d;
    logic toggle_q, toggle_d;
    logic soft_rst_q, soft_rst_d;
    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;

    function automatic logic [15:0] read_mux(input logic [4:0] addr,
                                             input logic [15:0] stat,
                                             input logic [15:0] boost);
        case (addr)
            `BSC_RD_STATUS: read_mux = stat;
            `BSC_RD_BOOST: read_mux = boost;
            default: read_mux = '0;
        endcase
    endfunction

    assign opcode = wr_data_i[`BSC_OP_MSB:`BSC_OP_LSB];
    assign code = wr_data_i[`BSC_CODE_MSB:`BSC_CODE_LSB];
    assign sw_wr = wr_valid_i && (opcode == `BSC_OP_SOFTWARE);
    assign boost_wr = wr_valid_i && (opcode == `BSC_OP_BOOST);
    assign reset_cmd = sw_wr && (code == `BSC_CODE_RESET);
    assign service_cmd = sw_wr && (code == `BSC_CODE_SERVICE);

    always_comb begin
        logic [15:0] stat;
        logic [15:0] boost;
        stat = '0;
        stat[`BSC_STAT_TOGGLE_BIT] = toggle_q;
        boost = '0;
        boost[`BSC_COMP_BIT] = comp_q;
        boost[`BSC_PHASE_MSB:`BSC_PHASE_LSB] = phase_q;
        boost[`BSC_RATE_MSB:`BSC_RATE_LSB] = rate_q;
        boost[`BSC_VLIM_MSB:`BSC_VLIM_LSB] = vlim_q;

        comp_d = comp_q;
        phase_d = phase_q;
        rate_d = rate_q;
        vlim_d = vlim_q;
        toggle_d = toggle_q;
        if (sw_wr) begin
            toggle_d = wr_data_i[`BSC_ECHO_BIT];
        end
        if (boost_wr) begin
            comp_d = wr_data_i[`BSC_COMP_BIT];
            phase_d = wr_data_i[`BSC_PHASE_MSB:`BSC_PHASE_LSB];
            vlim_d = wr_data_i[`BSC_VLIM_MSB:`BSC_VLIM_LSB];
            if (wr_data_i[`BSC_RATE_MSB:`BSC_RATE_LSB] != `BSC_RATE_UNDEF) begin
                rate_d = wr_data_i[`BSC_RATE_MSB:`BSC_RATE_LSB];
            end
        end
        // Full reset wins over the echo bit carried in the same word
        if (reset_cmd) begin
            comp_d = `BSC_COMP_RST;
            phase_d = `BSC_PHASE_RST;
            rate_d = `BSC_RATE_RST;
            vlim_d = `BSC_VLIM_RST;
            toggle_d = `BSC_TOGGLE_RST;
        end
        soft_rst_d = reset_cmd;

        // Readback shows the contents before any write in the same cycle
        rd_valid_d = rd_req_i;
        rd_data_d = rd_data_q;
        if (rd_req_i) begin
            rd_data_d = read_mux(rd_addr_i, stat, boost);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            comp_q <= `BSC_COMP_RST;
            phase_q <= `BSC_PHASE_RST;
            rate_q <= `BSC_RATE_RST;
            vlim_q <= `BSC_VLIM_RST;
            toggle_q <= `BSC_TOGGLE_RST;
            soft_rst_q <= 1'b0;
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            comp_q <= comp_d;
            phase_q <= phase_d;
            rate_q <= rate_d;
            vlim_q <= vlim_d;
            toggle_q <= toggle_d;
            soft_rst_q <= soft_rst_d;
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    bsc_watchdog #(
        .TIMEOUT_CYCLES(WDT_TIMEOUT_CYCLES)
    ) u_watchdog (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .enable_i(wdt_enable_i),
        .service_i(service_cmd),
        .clear_i(reset_cmd),
        .alert_o(alert_o)
    );

    bsc_phase_gen #(
        .CHANNELS(CHANNELS)
    ) u_phase_gen (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .rate_i(rate_q),
        .phasing_i(phase_q),
        .switch_clk_o(boost_switch_clk_o)
    );

    assign rd_data_o = rd_data_q;
    assign rd_valid_o = rd_valid_q;
    assign soft_reset_o = soft_rst_q;
    assign user_toggle_o = toggle_q;
    assign boost_compensation_select_o = comp_q;
    assign boost_phasing_select_o = phase_q;
    assign boost_switching_rate_select_o = rate_q;
    assign boost_voltage_limit_select_o = vlim_q;

endmodule // bsc_regs

`default_nettype wire

// File: sim/bsc_regs_chk.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_regs_chk #(
    parameter int unsigned WDT_TIMEOUT_CYCLES = 100000,
    parameter int unsigned CHANNELS = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic wr_valid_i,
    input wire logic [15:0] wr_data_i,
    input wire logic rd_req_i,
    input wire logic [4:0] rd_addr_i,
    input wire logic wdt_enable_i,
    input wire logic [15:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic soft_reset_o,
    input wire logic alert_o,
    input wire logic user_toggle_o,
    input wire logic boost_compensation_select_o,
    input wire logic [1:0] boost_phasing_select_o,
    input wire logic [1:0] boost_switching_rate_select_o,
    input wire logic [1:0] boost_voltage_limit_select_o,
    input wire logic [CHANNELS-1:0] boost_switch_clk_o
);
    logic [6:0] bw;
    logic sw;
    logic bo;
    int cnt_q;
    assign bw = {boost_compensation_select_o, boost_phasing_select_o,
                 boost_switching_rate_select_o, boost_voltage_limit_select_o};
    assign sw = wr_valid_i && wr_data_i[15:13] == 3'h4;
    assign bo = wr_valid_i && wr_data_i[15:13] == 3'h3;

    // Unserviced enabled cycles; saturates so long faults cannot wrap
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i)
            cnt_q <= 0;
        else if (!wdt_enable_i || (sw && wr_data_i[11:0] inside {12'h195, 12'h555}))
            cnt_q <= 0;
        else if (cnt_q < WDT_TIMEOUT_CYCLES + 8)
            cnt_q <= cnt_q + 1;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    property p_rdv; rd_req_i |=> rd_valid_o; endproperty
    a_rdv: assert property (p_rdv) else $error("read answer missing");
    property p_rdb; rd_req_i && rd_addr_i == 5'h1a |=> rd_data_o == {9'h0, $past(bw)}; endproperty
    a_rdb: assert property (p_rdb) else $error("boost readback wrong");
    property p_echo; sw && wr_data_i[11:0] != 12'h555 |=> user_toggle_o == $past(wr_data_i[12]);
    endproperty
    a_echo: assert property (p_echo) else $error("echo bit wrong");
    property p_srst; sw && wr_data_i[11:0] == 12'h555 |=> soft_reset_o && bw == 7'h04; endproperty
    a_srst: assert property (p_srst) else $error("soft reset wrong");
    property p_boost; bo && wr_data_i[3:2] != 2'h3 |=> bw == $past(wr_data_i[6:0]); endproperty
    a_boost: assert property (p_boost) else $error("boost fields wrong");
    property p_keep; bo && wr_data_i[3:2] == 2'h3 |=> $stable(boost_switching_rate_select_o);
    endproperty
    a_keep: assert property (p_keep) else $error("undefined rate taken");
    property p_svc; sw && wdt_enable_i && wr_data_i[11:0] == 12'h195 |=> !alert_o; endproperty
    a_svc: assert property (p_svc) else $error("service did not clear");
    property p_early; $rose(alert_o) |-> cnt_q >= WDT_TIMEOUT_CYCLES; endproperty
    a_early: assert property (p_early) else $error("alert too early");
    property p_late; cnt_q > WDT_TIMEOUT_CYCLES + 3 |-> alert_o; endproperty
    a_late: assert property (p_late) else $error("alert missing");
endmodule // bsc_regs_chk

bind bsc_regs bsc_regs_chk #(
    .WDT_TIMEOUT_CYCLES(WDT_TIMEOUT_CYCLES),
    .CHANNELS(CHANNELS)
) chk (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .wr_valid_i(wr_valid_i),
    .wr_data_i(wr_data_i),
    .rd_req_i(rd_req_i),
    .rd_addr_i(rd_addr_i),
    .wdt_enable_i(wdt_enable_i),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .soft_reset_o(soft_reset_o),
    .alert_o(alert_o),
    .user_toggle_o(user_toggle_o),
    .boost_compensation_select_o(boost_compensation_select_o),
    .boost_phasing_select_o(boost_phasing_select_o),
    .boost_switching_rate_select_o(boost_switching_rate_select_o),
    .boost_voltage_limit_select_o(boost_voltage_limit_select_o),
    .boost_switch_clk_o(boost_switch_clk_o)
);

`default_nettype wire

// File: sim/bsc_host.sv
`timescale 1ns/1ps
`default_nettype none

module bsc_host (
    input wire logic clk_i,
    input wire logic rd_valid_i,
    input wire logic [15:0] rd_data_i,
    output logic wr_valid_o,
    output logic [15:0] wr_data_o,
    output logic rd_req_o,
    output logic [4:0] rd_addr_o
);
    initial begin
        wr_valid_o = 1'b0;
        wr_data_o = 16'h0;
        rd_req_o = 1'b0;
        rd_addr_o = 5'h0;
    end

    task automatic write(input logic [15:0] d);
        @(posedge clk_i);
        #1;
        wr_valid_o = 1'b1;
        wr_data_o = d;
        @(posedge clk_i);
        #1;
        wr_valid_o = 1'b0;
        wr_data_o = ~d; // Released lines must not keep the last word
    endtask

    task automatic read(input logic [4:0] a, output logic v, output logic [15:0] d);
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b1;
        rd_addr_o = a;
        @(posedge clk_i);
        #1;
        rd_req_o = 1'b0;
        rd_addr_o = ~a;
        v = rd_valid_i;
        d = rd_data_i;
    endtask
endmodule // bsc_host

`default_nettype wire

// File: sim/test_boost_and_software_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_boost_and_software_control_regs;
    logic clk_i;
    logic resetn_i;
    logic wdt_en;
    logic wv, rq, rv, srst, alert, tog, comp, v, b;
    logic [15:0] wd, rdat, rd, d, ob;
    logic [4:0] ra;
    logic [1:0] ph, rate, vlim;
    logic [3:0] sc;
    logic [6:0] eb;
    logic [31:0] st = 32'h20;
    logic [31:0] r;
    int fails = 0;
    int n_tests = 0;
    time t0;

    assign ob = {9'h0, comp, ph, rate, vlim};
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    bsc_regs #(.WDT_TIMEOUT_CYCLES(20), .CHANNELS(4)) uut (.clk_i(clk_i), .resetn_i(resetn_i),
        .wr_valid_i(wv), .wr_data_i(wd), .rd_req_i(rq), .rd_addr_i(ra), .wdt_enable_i(wdt_en),
        .rd_data_o(rdat), .rd_valid_o(rv), .soft_reset_o(srst), .alert_o(alert),
        .user_toggle_o(tog), .boost_compensation_select_o(comp), .boost_phasing_select_o(ph),
        .boost_switching_rate_select_o(rate), .boost_voltage_limit_select_o(vlim),
        .boost_switch_clk_o(sc));
    bsc_host host (.clk_i(clk_i), .rd_valid_i(rv), .rd_data_i(rdat), .wr_valid_o(wv),
        .wr_data_o(wd), .rd_req_o(rq), .rd_addr_o(ra));

    function automatic logic [31:0] xs();
        st ^= st << 13;
        st ^= st >> 17;
        st ^= st << 5;
        return st;
    endfunction

    // Undefined rate code leaves the rate alone, the other fields still load
    function automatic logic [6:0] nb(input logic [6:0] o, input logic [15:0] w);
        return {w[6:4], (w[3:2] == 2'h3) ? o[3:2] : w[3:2], w[1:0]};
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait for the alert; r returns the cycles spent
    task automatic wait_alert();
        t0 = $time;
        for (int k = 0; k < 40 && !alert; k++) begin
            cyc(1);
        end
        r = 32'(($time - t0) / 100);
    endtask

    task automatic rise();
        logic pv;
        int k;
        pv = sc[0];
        cyc(1);
        for (k = 0; k < 100 && !(sc[0] && !pv); k++) begin
            pv = sc[0];
            cyc(1);
        end
        if (k == 100) begin
            fails++;
            give_verdict();
        end
    endtask

    initial begin
        resetn_i = 1'b0;
        wdt_en = 1'b0;
        cyc(5);
        resetn_i = 1'b1;
        chk(ob, 16'h0004);
        eb = 7'h04;
        for (int i = 0; i < 64; i++) begin
            r = xs();
            d = {3'h3, r[12:7], r[0], i[5:0]};
            host.write(d);
            eb = nb(eb, d);
            chk(ob, {9'h0, eb});
            host.read(5'h1a, v, rd);
            chk(rd, {9'h0, eb});
            chk(16'(v), 16'h1);
        end
        for (int j = 0; j < 8; j++) begin
            if (j inside {3, 4})
                continue;
            host.write({j[2:0], 13'h1fff});
            chk(ob, {9'h0, eb});
        end
        for (int e = 0; e < 2; e++) begin
            host.write({3'h4, e[0], 12'h0a5});
            chk(16'(tog), 16'(e[0]));
            host.read(5'h18, v, rd);
            chk(rd, {4'h0, e[0], 11'h0});
        end
        host.read(5'h07, v, rd);
        chk(rd, 16'h0);
        host.write(16'h607b);
        host.write(16'h9555);
        chk({7'h0, srst, tog, ob[6:0]}, 16'h0104);
        for (int k = 0; k < 3; k++) begin
            host.write({12'h600, k[1:0], 2'h0});
            rise();
            chk(16'(sc), 16'({4{sc[0]}}));
            t0 = $time;
            rise();
            chk(16'(($time - t0) / 100), (k == 0) ? 16'h28 : (k == 1) ? 16'h18 : 16'h0f);
        end
        host.write(16'h6014);
        cyc(3);
        chk(16'(sc), 16'({~sc[0], ~sc[0], sc[0], sc[0]}));
        host.write(16'h6024);
        cyc(3);
        chk(16'(sc), 16'({~sc[0], sc[0], ~sc[0], sc[0]}));
        // Quadrature: C and D opposite A and B, B a quarter period off A
        host.write(16'h6034);
        rise();
        b = sc[1];
        chk(16'({sc[3] ^ sc[1], sc[2]}), 16'h2);
        cyc(6);
        chk(16'({sc[0], sc[1] ^ b}), 16'h3);
        wdt_en = 1'b1;
        repeat (5) begin
            host.write(16'h8195);
            cyc(8);
            chk(16'(alert), 16'h0);
        end
        wait_alert();
        chk(16'(r >= 12 && r <= 16), 16'h1);
        host.write(16'h9195);
        chk({14'h0, alert, tog}, 16'h1);
        wait_alert();
        chk(16'(alert), 16'h1);
        // Mid-run reset while the watchdog is in fault
        resetn_i = 1'b0;
        cyc(2);
        resetn_i = 1'b1;
        chk({7'h0, alert, tog, ob[6:0]}, 16'h0004);
        wait_alert();
        chk(16'(r >= 20 && r <= 23), 16'h1);
        wdt_en = 1'b0;
        cyc(1);
        chk(16'(alert), 16'h0);
        give_verdict();
    end
endmodule // test_boost_and_software_control_regs

`default_nettype wire
